// *** logic/sbp_port.sv ***
// Synchronous bus port of a pipelined burst SRAM
`timescale 1ns/1ps
module sbp_port #(
   parameter bit HAS_THIRD_SELECT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Synchronous bus from the controller
   input wire sbp_pkg::sbp_bus_t bus,
   input wire logic [sbp_pkg::DATA_W-1:0] dq_in,
   // Asynchronous pins
   input wire logic output_drive_enable_n,
   input wire logic sleep_request,
   // Data pin drive
   output logic [sbp_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   // Memory array side and sleep status
   output sbp_pkg::sbp_mem_req_t mem_req,
   input wire logic [sbp_pkg::DATA_W-1:0] mem_rdata,
   output logic sleeping
);
   // ----------------------------------------
   // State and decode
   // ----------------------------------------
   sbp_pkg::sbp_regs_t r;
   sbp_pkg::sbp_regs_t next_r;
   logic sel;
   logic p_win;
   logic strobe;
   logic go;
   logic [sbp_pkg::LANES-1:0] lanes;

   // Missing third select reads as asserted
   assign sel = !bus.first_select_n && bus.second_select
      && (!bus.third_select_n || !HAS_THIRD_SELECT);
   // Processor strobe needs first select low and beats the controller strobe
   assign p_win = !bus.processor_addr_strobe_n && !bus.first_select_n;
   assign strobe = p_win || !bus.controller_addr_strobe_n;
   // Global write overrides the lane writes and the gate
   assign lanes = !bus.all_bytes_write_n ? sbp_pkg::ALL_LANES :
      (!bus.byte_write_gate_n ? ~bus.byte_lane_write_n : sbp_pkg::NO_LANES);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_r = r;
      go = 1'b0;
      // Sleep is an asynchronous pin, so it is synchronised first
      next_r.sleep_meta = sleep_request;
      next_r.sleep = r.sleep_meta;
      next_r.req.rd = 1'b0;
      next_r.req.wr_lanes = sbp_pkg::NO_LANES;
      next_r.mask = 1'b0;
      next_r.rd_valid = r.req.rd;
      if (r.req.rd) begin
         next_r.dq_out = mem_rdata;
      end
      if (r.sleep) begin
         next_r.state = sbp_pkg::SBP_IDLE;
      end else if (strobe) begin
         if (sel) begin
            next_r.addr_hi = bus.addr[sbp_pkg::ADDR_W-1:sbp_pkg::CNT_W];
            next_r.cnt = bus.addr[sbp_pkg::CNT_W-1:0];
            next_r.state = sbp_pkg::SBP_BURST;
            go = 1'b1;
         end else begin
            next_r.state = sbp_pkg::SBP_IDLE;
         end
      end else if (r.state == sbp_pkg::SBP_BURST) begin
         go = 1'b1;
         if (!bus.burst_step_n) begin
            // Linear step, wraps inside the four-word group
            next_r.cnt = r.cnt + sbp_pkg::CNT_STEP;
         end
      end
      if (go) begin
         next_r.req.addr = {next_r.addr_hi, next_r.cnt};
         // A processor strobe always starts with a read; writes follow it
         if (!p_win && lanes != sbp_pkg::NO_LANES) begin
            next_r.req.wr_lanes = lanes;
            next_r.req.wdata = dq_in;
         end else begin
            next_r.req.rd = 1'b1;
            next_r.mask = (r.state == sbp_pkg::SBP_IDLE);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         r <= sbp_pkg::REGS_RST;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Drive enable is combinational from the pin so it acts without the clock
   assign dq_oe = !output_drive_enable_n && !r.sleep && !r.mask
      && (r.state == sbp_pkg::SBP_BURST || r.rd_valid);
   assign dq_out = r.dq_out;
   assign mem_req = r.req;
   assign sleeping = r.sleep;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   logic plain_burst;
   assign plain_burst = r.state == sbp_pkg::SBP_BURST && !strobe && !r.sleep;

   a_addr_latch: assert property (
      (!r.sleep && strobe && sel) |=> (r.state == sbp_pkg::SBP_BURST
      && r.addr_hi == $past(bus.addr[sbp_pkg::ADDR_W-1:sbp_pkg::CNT_W])))
      else $error("address not latched on selected strobe");
   a_cnt_load: assert property (
      (!r.sleep && strobe && sel) |=> r.cnt == $past(bus.addr[sbp_pkg::CNT_W-1:0]))
      else $error("burst counter not loaded");
   a_desel_strobe: assert property (
      (!r.sleep && strobe && !sel) |=> (r.state == sbp_pkg::SBP_IDLE && !r.req.rd
      && r.req.wr_lanes == sbp_pkg::NO_LANES))
      else $error("access while deselected");
   a_proc_ignored: assert property (
      (bus.first_select_n && !bus.processor_addr_strobe_n
      && bus.controller_addr_strobe_n && r.state == sbp_pkg::SBP_IDLE && !r.sleep)
      |=> (r.state == sbp_pkg::SBP_IDLE && !r.req.rd))
      else $error("processor strobe taken with first select high");
   a_proc_wins: assert property (
      (!r.sleep && p_win && sel && !bus.controller_addr_strobe_n)
      |=> (r.req.rd && r.req.wr_lanes == sbp_pkg::NO_LANES))
      else $error("controller strobe acted on with processor strobe");
   a_global_write: assert property (
      (plain_burst && !bus.all_bytes_write_n) |=> r.req.wr_lanes == sbp_pkg::ALL_LANES)
      else $error("global write missed a lane");
   a_byte_write: assert property (
      (plain_burst && bus.all_bytes_write_n) |=> r.req.wr_lanes ==
      ($past(bus.byte_write_gate_n) ? sbp_pkg::NO_LANES : ~$past(bus.byte_lane_write_n)))
      else $error("byte lanes wrong");
   a_burst_step: assert property (
      (plain_burst && !bus.burst_step_n) |=> (r.cnt == $past(r.cnt) + sbp_pkg::CNT_STEP
      && r.addr_hi == $past(r.addr_hi) && r.req.addr == {r.addr_hi, r.cnt}))
      else $error("burst step wrong");
   a_read_data: assert property (
      r.req.rd |=> (r.rd_valid && r.dq_out == $past(mem_rdata)))
      else $error("read data not captured");
   a_first_mask: assert property (
      (r.state == sbp_pkg::SBP_IDLE && !r.sleep && strobe && sel && next_r.req.rd)
      |=> !dq_oe)
      else $error("drove pins in first read clock");
   a_oe_high: assert property (
      output_drive_enable_n |-> !dq_oe)
      else $error("drove pins with enable high");
   a_sleep_idle: assert property (
      r.sleep |=> (!r.req.rd && r.req.wr_lanes == sbp_pkg::NO_LANES))
      else $error("access during sleep");

   // ----------------------------------------
   // Select, load, burst and write data
   // ----------------------------------------
   a_third_absent: assert property (
      (!HAS_THIRD_SELECT && !bus.first_select_n && bus.second_select
      && bus.third_select_n)
      |-> sel)
      else $error("absent third select not taken as asserted");
   a_proc_load: assert property (
      (!r.sleep && p_win && sel)
      |=> (r.req.addr == $past(bus.addr) && r.req.rd
      && r.state == sbp_pkg::SBP_BURST))
      else $error("processor strobe did not load the address");
   a_ctl_load: assert property (
      (!r.sleep && !p_win && !bus.controller_addr_strobe_n && sel)
      |=> (r.req.addr == $past(bus.addr)
      && r.cnt == $past(bus.addr[sbp_pkg::CNT_W-1:0])))
      else $error("controller strobe did not load the address");
   a_idle_hold: assert property (
      (r.state == sbp_pkg::SBP_IDLE && !strobe && !r.sleep)
      |=> (r.state == sbp_pkg::SBP_IDLE && !r.req.rd
      && r.req.wr_lanes == sbp_pkg::NO_LANES))
      else $error("access without an address strobe");
   a_suspend: assert property (
      (plain_burst && bus.burst_step_n)
      |=> (r.cnt == $past(r.cnt) && r.addr_hi == $past(r.addr_hi)
      && r.req.addr == {r.addr_hi, r.cnt}))
      else $error("burst address moved without a step");
   a_wrap_four: assert property (
      ((plain_burst && !bus.burst_step_n) [*4])
      |=> (r.cnt == $past(r.cnt, 4)
      && r.addr_hi == $past(r.addr_hi, 4)))
      else $error("burst did not wrap in its group");
   a_wdata: assert property (
      (plain_burst && lanes != sbp_pkg::NO_LANES)
      |=> (r.req.wdata == $past(dq_in)
      && r.req.wr_lanes == $past(lanes)))
      else $error("write data not captured");

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   a_oe_drive: assert property (
      (!output_drive_enable_n && !r.sleep && !r.mask
      && r.state == sbp_pkg::SBP_BURST)
      |-> dq_oe)
      else $error("pins not driven with enable low");

   // ----------------------------------------
   // Cover points
   // ----------------------------------------
   c_burst_four: cover property ((plain_burst && !bus.burst_step_n) [*3]);
   c_global_write: cover property (r.req.wr_lanes == sbp_pkg::ALL_LANES);
   c_read_driven: cover property (r.rd_valid && dq_oe);
   c_proc_read: cover property (p_win && sel && !r.sleep);
   c_wrap: cover property (plain_burst && !bus.burst_step_n && r.cnt == 2'h3);
endmodule : sbp_port

// *** logic/sbp_pkg.sv ***
// Constants and carriers for the pipelined burst SRAM bus port
// Behaviour
// - Latch address only on a strobe while every chip select is active.
// - An address strobe loads the low two address bits into the burst counter.
// - A lane is written when its lane write and the byte write gate are low.
// - All-bytes write low writes every lane, ignoring lane writes and gate.
// - Every synchronous input is captured on the rising clock edge.
// - During a burst, burst step low increments the burst counter each edge.
// - Burst step produces the next burst address without a new external address.
// - Selected only when first select low, second high and third low.
// - Variants without the third select treat it as always asserted.
// - Processor strobe is ignored whenever first select is high.
// - Processor strobe low captures the address and loads the burst counter.
// - With both strobes low, only the processor strobe is acted on.
// - Output drive enable low drives the data pins, without the clock.
// - Output drive enable high leaves data pins undriven, usable as write inputs.
// - Data pins stay undriven in the first clock of a read from deselect.
// - Controller strobe low captures the address and loads the burst counter.
// - Write data is captured on the edge; read data follows the previous edge.
// - Sleep request high stops all accesses and keeps stored data.
package sbp_pkg;
   // ----------------------------------------
   // Widths and constants
   // ----------------------------------------
   localparam int ADDR_W = 19;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = 36;
   localparam int CNT_W = 2;
   localparam logic [LANES-1:0] ALL_LANES = 4'hF;
   localparam logic [LANES-1:0] NO_LANES = 4'h0;
   localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SBP_IDLE = 2'b01,
      SBP_BURST = 2'b10
   } sbp_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic first_select_n;
      logic second_select;
      logic third_select_n;
      logic processor_addr_strobe_n;
      logic controller_addr_strobe_n;
      logic burst_step_n;
      logic [LANES-1:0] byte_lane_write_n;
      logic byte_write_gate_n;
      logic all_bytes_write_n;
   } sbp_bus_t;

   typedef struct packed {
      logic rd;
      logic [LANES-1:0] wr_lanes;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } sbp_mem_req_t;

   typedef struct packed {
      sbp_state_t state;
      logic [ADDR_W-CNT_W-1:0] addr_hi;
      logic [CNT_W-1:0] cnt;
      sbp_mem_req_t req;
      logic mask;
      logic rd_valid;
      logic [DATA_W-1:0] dq_out;
      logic sleep_meta;
      logic sleep;
   } sbp_regs_t;

   localparam sbp_regs_t REGS_RST = '{state: SBP_IDLE, default: '0};
endpackage : sbp_pkg

// *** sim/sbp_mem_model.sv ***
// Behavioural memory array behind the bus port
`timescale 1ns/1ps
module sbp_mem_model (
   // Clock
   input wire logic clk,
   // Requests from the port
   input wire sbp_pkg::sbp_mem_req_t mem_req,
   // Read answer
   output logic [sbp_pkg::DATA_W-1:0] mem_rdata
);
   logic [sbp_pkg::DATA_W-1:0] mem [64];
   initial begin
      foreach (mem[i]) begin
         mem[i] = '0;
      end
   end
   // Outside a read the answer is inverted, so stale data never passes for valid
   assign mem_rdata = mem_req.rd ? mem[mem_req.addr[5:0]] : ~mem[mem_req.addr[5:0]];
   always @(posedge clk) begin
      for (int i = 0; i < sbp_pkg::LANES; i++) begin
         if (mem_req.wr_lanes[i]) begin
            mem[mem_req.addr[5:0]][i*9 +: 9] <= mem_req.wdata[i*9 +: 9];
         end
      end
   end
endmodule : sbp_mem_model

// *** sim/sbp_port_tb.sv ***
// Self-checking bench for the SRAM bus port
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin fail_count++; \
$display("BAD %s exp %h got %h", n, e, s); end end
module sbp_port_tb;
   localparam sbp_pkg::sbp_bus_t IDLE = '{addr: '0, first_select_n: 1'b0,
      third_select_n: 1'b0, byte_lane_write_n: 4'hF, default: 1'b1};
   localparam logic [35:0] D1 = 36'h9_1234_5678;
   localparam logic [35:0] D2 = 36'h6_ABCD_EF01;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   sbp_pkg::sbp_bus_t bus = IDLE;
   logic [sbp_pkg::DATA_W-1:0] dq_in = '0;
   logic oe_n = 1'b1;
   logic zz = 1'b0;
   logic [sbp_pkg::DATA_W-1:0] dq_out, rdata;
   logic dq_oe, sleeping;
   sbp_pkg::sbp_mem_req_t req;
   sbp_pkg::sbp_bus_t b;
   int fail_count = 0;
   int num_checks = 0;
   always #50 clk = ~clk;
   sbp_port dut (.clk(clk), .nrst(nrst), .bus(bus), .dq_in(dq_in),
      .output_drive_enable_n(oe_n), .sleep_request(zz), .dq_out(dq_out), .dq_oe(dq_oe),
      .mem_req(req), .mem_rdata(rdata), .sleeping(sleeping));
   sbp_mem_model mem (.clk(clk), .mem_req(req), .mem_rdata(rdata));
   // Inputs change at the falling edge only
   task automatic step(input sbp_pkg::sbp_bus_t v);
      @(negedge clk);
      bus = v;
   endtask : step
   function automatic sbp_pkg::sbp_bus_t ctl(input logic [18:0] a);
      ctl = IDLE;
      ctl.addr = a;
      ctl.controller_addr_strobe_n = 1'b0;
   endfunction : ctl
   task automatic t_writes();
      b = ctl(19'h10);
      b.all_bytes_write_n = 1'b0;
      dq_in = D1;
      step(b);
      step(IDLE);
      `CHK("glob lanes", 4'hF, req.wr_lanes)
      `CHK("wdata", D1, req.wdata)
      `CHK("addr", 19'h10, req.addr)
      b = ctl(19'h10);
      b.byte_write_gate_n = 1'b0;
      b.byte_lane_write_n = 4'hA;
      dq_in = D2;
      step(b);
      step(IDLE);
      `CHK("byte lanes", 4'h5, req.wr_lanes)
      b.byte_write_gate_n = 1'b1;
      step(b);
      step(IDLE);
      `CHK("no gate", 4'h0, req.wr_lanes)
      step(ctl(19'h10));
      step(IDLE);
      step(IDLE);
      `CHK("rdback", {D1[35:27], D2[26:18], D1[17:9], D2[8:0]}, dq_out)
   endtask : t_writes
   task automatic t_burst();
      b = IDLE;
      b.burst_step_n = 1'b0;
      step(ctl(19'h13));
      step(b);
      `CHK("load", 19'h13, req.addr)
      step(IDLE);
      `CHK("wrap", 19'h10, req.addr)
   endtask : t_burst
   task automatic t_select();
      b = ctl(19'h20);
      b.second_select = 1'b0;
      step(b);
      step(IDLE);
      `CHK("desel", 1'b0, req.rd)
      b = IDLE;
      b.processor_addr_strobe_n = 1'b0;
      b.first_select_n = 1'b1;
      step(b);
      step(IDLE);
      `CHK("ps ign", 1'b0, req.rd)
      oe_n = 1'b0;
      b = ctl(19'h24);
      b.processor_addr_strobe_n = 1'b0;
      b.all_bytes_write_n = 1'b0;
      step(b);
      step(IDLE);
      `CHK("ps rd", 1'b1, req.rd)
      `CHK("ps nowr", 4'h0, req.wr_lanes)
      `CHK("ps addr", 19'h24, req.addr)
      `CHK("oe mask", 1'b0, dq_oe)
      step(IDLE);
      `CHK("oe on", 1'b1, dq_oe)
      @(negedge clk);
      oe_n = 1'b1;
      #1 `CHK("oe off", 1'b0, dq_oe)
   endtask : t_select
   task automatic t_sleep();
      zz = 1'b1;
      repeat (4) step(IDLE);
      `CHK("sleeping", 1'b1, sleeping)
      step(ctl(19'h10));
      step(IDLE);
      `CHK("slp rd", 1'b0, req.rd)
      zz = 1'b0;
      repeat (4) step(IDLE);
   endtask : t_sleep
   task automatic finish_test();
      if (fail_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      #100000 fail_count++;
      finish_test();
   end
   initial begin
      repeat (8) @(negedge clk);
      `CHK("rst rd", 1'b0, req.rd)
      nrst = 1'b1;
      t_writes();
      t_burst();
      t_select();
      t_sleep();
      finish_test();
   end
endmodule : sbp_port_tb
